// [rrsb_pkg.sv]
// shared types and constants for the rotate-right / subtract-with-borrow datapath
package rrsb_pkg;
    localparam int RRSB_W = 8;
    localparam int RRSB_MSB = 7;
    localparam int RRSB_NIB = 4;
    localparam logic [7:0] RRSB_ZERO = 8'h00;
    localparam logic [7:0] RRSB_WORK_RST = 8'h00;

    typedef enum logic [2:0] {
        RRSB_OP_NONE,
        RRSB_OP_ROT_RIGHT_MEM,
        RRSB_OP_ROT_RIGHT_TO_WORK_REG,
        RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM,
        RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG,
        RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG,
        RRSB_OP_SUB_WITH_BORROW_TO_MEM
    } rrsb_op_t;

    // status flags held by the core
    typedef struct packed {
        logic signed_wrap_flag;
        logic result_null_flag;
        logic nibble_borrow_flag;
        logic borrow_inverse_bit;
        logic signed_borrow_flag;
        logic chained_null_flag;
    } rrsb_flags_t;

    localparam rrsb_flags_t RRSB_FLAGS_RST = '0;

    // one instruction request from the decoder
    typedef struct packed {
        logic valid;
        rrsb_op_t op;
        logic [7:0] mem_data;
    } rrsb_req_t;

    // result toward memory
    typedef struct packed {
        logic write;
        logic [7:0] data;
    } rrsb_mem_wr_t;
endpackage

// [rrsb_alu.sv]
// combinational rotate and subtract unit
`timescale 1ns/1ns
module rrsb_alu
    import rrsb_pkg::*;
(
    input wire rrsb_op_t i_op,
    input wire logic [7:0] i_mem,
    input wire logic [7:0] i_work,
    input wire rrsb_flags_t i_flags,
    output logic [7:0] o_result,
    output rrsb_flags_t o_flags
);
    logic [8:0] diff;
    logic [4:0] low_diff;
    logic borrow_in;

    always_comb begin
        borrow_in = ~i_flags.borrow_inverse_bit;
        diff = {1'b0, i_work} - {1'b0, i_mem} - {8'h00, borrow_in};
        low_diff = {1'b0, i_work[3:0]} - {1'b0, i_mem[3:0]} - {4'h0, borrow_in};
        o_result = i_mem;
        o_flags = i_flags;
        case (i_op)
            RRSB_OP_ROT_RIGHT_MEM, RRSB_OP_ROT_RIGHT_TO_WORK_REG: begin
                o_result = {i_mem[0], i_mem[RRSB_MSB:1]}; // RQ1
            end
            RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM, RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG: begin
                o_result = {i_flags.borrow_inverse_bit, i_mem[RRSB_MSB:1]}; // RQ3
                o_flags.borrow_inverse_bit = i_mem[0]; // RQ4
            end
            RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG, RRSB_OP_SUB_WITH_BORROW_TO_MEM: begin
                o_result = diff[7:0]; // RQ5
                o_flags.borrow_inverse_bit = ~diff[8]; // RQ7
                o_flags.nibble_borrow_flag = ~low_diff[4]; // RQ8
                o_flags.signed_wrap_flag = (i_work[7] ^ i_mem[7]) & (i_work[7] ^ diff[7]); // RQ8
                o_flags.result_null_flag = (diff[7:0] == RRSB_ZERO); // RQ8
                // signed view: true sign of the 9-bit signed difference
                o_flags.signed_borrow_flag = diff[7] ^ o_flags.signed_wrap_flag; // RQ8
                // chained zero keeps prior zero so multi-byte compares work
                // limitation: it starts clear and no op in this project sets it, so the chain never seeds
                o_flags.chained_null_flag = (diff[7:0] == RRSB_ZERO) & i_flags.chained_null_flag; // RQ8
            end
            default: begin
                o_result = i_mem;
            end
        endcase
    end
endmodule // rrsb_alu

// [rrsb_top.sv]
// datapath for right rotates and subtract with borrow
`timescale 1ns/1ns
// What this block does
// RQ1 - memory rotate right: bit0 goes to bit7, result to memory, flags kept.
// RQ2 - rotate right to work_reg: memory untouched, flags kept.
// RQ3 - through-borrow rotate: nine-bit ring with borrow_inverse_bit, result to memory.
// RQ4 - through-borrow rotate to work_reg: borrow bit from memory bit0, memory kept.
// RQ5 - subtract: work_reg minus memory minus inverse borrow bit, into work_reg.
// RQ6 - subtract to memory: same difference written to memory instead.
// RQ7 - after subtract, borrow bit is 0 if negative, else 1.
// RQ8 - subtract updates six flags; through-borrow rotates only the borrow bit.
module rrsb_top
    import rrsb_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire rrsb_req_t i_req,
    output rrsb_mem_wr_t o_mem_wr,
    output logic [7:0] o_work_reg,
    output rrsb_flags_t o_flags
);
    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic [7:0] work_reg;
        rrsb_flags_t flags;
        rrsb_mem_wr_t mem_wr;
    } rrsb_state_t;

    localparam rrsb_state_t RRSB_STATE_RST = '{rst_meta: 1'b0, rst_sync: 1'b0, work_reg: RRSB_WORK_RST,
        flags: RRSB_FLAGS_RST, mem_wr: '0};

    rrsb_state_t st_reg;
    rrsb_state_t st_next;
    logic resetn_sync;
    logic [7:0] alu_result;
    rrsb_flags_t alu_flags;

    // op classes, shared by the strobe check and the hold checks
    function automatic logic op_writes_mem(input rrsb_op_t op);
        return op inside {RRSB_OP_ROT_RIGHT_MEM, RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM,
            RRSB_OP_SUB_WITH_BORROW_TO_MEM};
    endfunction

    function automatic logic op_writes_work(input rrsb_op_t op);
        return op inside {RRSB_OP_ROT_RIGHT_TO_WORK_REG, RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG,
            RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG};
    endfunction

    function automatic logic op_moves_flags(input rrsb_op_t op);
        return op inside {RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM, RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG,
            RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG, RRSB_OP_SUB_WITH_BORROW_TO_MEM};
    endfunction

    // reset release through two flops so all state leaves reset on one edge
    assign resetn_sync = st_reg.rst_sync;

    rrsb_alu u_alu (
        .i_op(i_req.op),
        .i_mem(i_req.mem_data),
        .i_work(st_reg.work_reg),
        .i_flags(st_reg.flags),
        .o_result(alu_result),
        .o_flags(alu_flags)
    );

    always_comb begin
        st_next = st_reg;
        st_next.rst_meta = 1'b1;
        st_next.rst_sync = st_reg.rst_meta;
        st_next.mem_wr.write = 1'b0;
        st_next.mem_wr.data = st_reg.mem_wr.data;
        if (i_req.valid) begin
            case (i_req.op)
                RRSB_OP_ROT_RIGHT_MEM: begin
                    st_next.mem_wr.write = 1'b1; // RQ1
                    st_next.mem_wr.data = alu_result;
                end
                RRSB_OP_ROT_RIGHT_TO_WORK_REG: begin
                    st_next.work_reg = alu_result; // RQ2
                end
                RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM: begin
                    st_next.mem_wr.write = 1'b1; // RQ3
                    st_next.mem_wr.data = alu_result;
                    st_next.flags.borrow_inverse_bit = alu_flags.borrow_inverse_bit; // RQ8
                end
                RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG: begin
                    st_next.work_reg = alu_result; // RQ4
                    st_next.flags.borrow_inverse_bit = alu_flags.borrow_inverse_bit; // RQ4
                end
                RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG: begin
                    st_next.work_reg = alu_result; // RQ5
                    st_next.flags = alu_flags; // RQ8
                end
                RRSB_OP_SUB_WITH_BORROW_TO_MEM: begin
                    st_next.mem_wr.write = 1'b1; // RQ6
                    st_next.mem_wr.data = alu_result;
                    st_next.flags = alu_flags; // RQ8
                end
                default: begin
                    st_next.mem_wr.write = 1'b0;
                end
            endcase
        end
        // datapath held at its reset values until the synchronised release
        if (!st_reg.rst_sync) begin
            st_next.work_reg = RRSB_WORK_RST;
            st_next.flags = RRSB_FLAGS_RST;
            st_next.mem_wr = '0;
        end
    end

    // one register stage for all state; the reset branch loads constants only
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= RRSB_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_mem_wr = st_reg.mem_wr;
    assign o_work_reg = st_reg.work_reg;
    assign o_flags = st_reg.flags;

    sequence s_req(rrsb_op_t op);
        resetn_sync && i_req.valid && i_req.op == op;
    endsequence

    AST_ROT_MEM: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ1
        s_req(RRSB_OP_ROT_RIGHT_MEM) |=> o_mem_wr.write
            && o_mem_wr.data == {$past(i_req.mem_data[0]), $past(i_req.mem_data[7:1])}
            && $stable(o_flags) && $stable(o_work_reg))
        else $error("rotate right to memory wrong");

    AST_ROT_WORK: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ2
        s_req(RRSB_OP_ROT_RIGHT_TO_WORK_REG) |=> !o_mem_wr.write && $stable(o_flags)
            && o_work_reg == {$past(i_req.mem_data[0]), $past(i_req.mem_data[7:1])})
        else $error("rotate right to work_reg wrong");

    AST_ROT_THRU_MEM: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ3
        s_req(RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM) |=> o_mem_wr.write
            && o_mem_wr.data == {$past(o_flags.borrow_inverse_bit), $past(i_req.mem_data[7:1])}
            && o_flags.borrow_inverse_bit == $past(i_req.mem_data[0]))
        else $error("rotate through borrow to memory wrong");

    AST_ROT_THRU_WORK: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ4
        s_req(RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG) |=> !o_mem_wr.write
            && o_work_reg == {$past(o_flags.borrow_inverse_bit), $past(i_req.mem_data[7:1])}
            && o_flags.borrow_inverse_bit == $past(i_req.mem_data[0]))
        else $error("rotate through borrow to work_reg wrong");

    AST_SUB_WORK: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ5
        s_req(RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG) |=> !o_mem_wr.write
            && o_work_reg == 8'($past(o_work_reg) - $past(i_req.mem_data)
                - {7'h00, ~$past(o_flags.borrow_inverse_bit)}))
        else $error("subtract to work_reg wrong");

    AST_SUB_MEM: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ6
        s_req(RRSB_OP_SUB_WITH_BORROW_TO_MEM) |=> o_mem_wr.write && $stable(o_work_reg)
            && o_mem_wr.data == 8'($past(o_work_reg) - $past(i_req.mem_data)
                - {7'h00, ~$past(o_flags.borrow_inverse_bit)}))
        else $error("subtract to memory wrong");

    AST_SUB_BORROW: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ7
        (s_req(RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG) or s_req(RRSB_OP_SUB_WITH_BORROW_TO_MEM))
            |=> o_flags.borrow_inverse_bit == ({1'b0, $past(o_work_reg)} >= ({1'b0, $past(i_req.mem_data)}
                + {8'h00, ~$past(o_flags.borrow_inverse_bit)})))
        else $error("borrow bit after subtract wrong");

    AST_SUB_ZERO: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ8
        s_req(RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG) |=> o_flags.result_null_flag == (o_work_reg == RRSB_ZERO))
        else $error("zero flag after subtract wrong");

    AST_ROT_THRU_FLAGS: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ8
        s_req(RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM) |=> o_flags.signed_wrap_flag == $past(o_flags.signed_wrap_flag)
            && o_flags.result_null_flag == $past(o_flags.result_null_flag)
            && o_flags.chained_null_flag == $past(o_flags.chained_null_flag))
        else $error("rotate through borrow touched other flags");

    // independent sign-extended reference for the subtract flags
    logic [9:0] sdiff_chk;
    logic nib_ok_chk;
    assign sdiff_chk = {{2{st_reg.work_reg[7]}}, st_reg.work_reg} - {{2{i_req.mem_data[7]}}, i_req.mem_data}
        - {9'h000, ~st_reg.flags.borrow_inverse_bit};
    assign nib_ok_chk = ({1'b0, st_reg.work_reg[3:0]}
        >= ({1'b0, i_req.mem_data[3:0]} + {4'h0, ~st_reg.flags.borrow_inverse_bit}));

    sequence s_any_sub;
        resetn_sync && i_req.valid && (i_req.op == RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG
            || i_req.op == RRSB_OP_SUB_WITH_BORROW_TO_MEM);
    endsequence

    sequence s_no_work_op;
        resetn_sync && !(i_req.valid && op_writes_work(i_req.op));
    endsequence

    sequence s_no_flag_op;
        resetn_sync && !(i_req.valid && op_moves_flags(i_req.op));
    endsequence

    AST_SUB_FLAGS: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ8
        s_any_sub |=> o_flags.signed_wrap_flag == $past(sdiff_chk[8] ^ sdiff_chk[7])
            && o_flags.signed_borrow_flag == $past(sdiff_chk[9])
            && o_flags.nibble_borrow_flag == $past(nib_ok_chk)
            && o_flags.result_null_flag == ($past(sdiff_chk[7:0]) == RRSB_ZERO)
            && o_flags.chained_null_flag == (o_flags.result_null_flag && $past(o_flags.chained_null_flag)))
        else $error("flags after subtract wrong");

    AST_WRITE_PULSE: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ2 RQ4
        o_mem_wr.write == $past(resetn_sync && i_req.valid && op_writes_mem(i_req.op)))
        else $error("memory write strobe wrong");

    AST_WORK_HELD: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ6
        s_no_work_op |=> $stable(o_work_reg))
        else $error("work_reg changed without a request");

    AST_FLAGS_HELD: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ1 RQ2
        s_no_flag_op |=> $stable(o_flags))
        else $error("flags changed without a flag-moving request");

    AST_ROT_THRU_WORK_FLAGS: assert property (@(posedge i_ref_clk) disable iff (!resetn_sync) // RQ8
        s_req(RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG) |=> o_flags.nibble_borrow_flag == $past(o_flags.nibble_borrow_flag)
            && o_flags.signed_borrow_flag == $past(o_flags.signed_borrow_flag)
            && o_flags.signed_wrap_flag == $past(o_flags.signed_wrap_flag))
        else $error("rotate through borrow to work_reg touched other flags");

    // outputs stay at reset values until the synchronised release
    AST_RESET_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !resetn_sync |-> o_work_reg == RRSB_WORK_RST && o_flags == RRSB_FLAGS_RST && !o_mem_wr.write)
        else $error("outputs moved before reset release");
endmodule // rrsb_top

// [rrsb_mem_model.sv]
// data memory byte behind the operand port
`timescale 1ns/1ns
module rrsb_mem_model
    import rrsb_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_load,
    input wire logic [7:0] i_load_data,
    input wire rrsb_mem_wr_t i_mem_wr,
    output logic [7:0] o_mem_data
);
    // a write lands one edge after the pulse, so the bench never reads back in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_load) begin
            o_mem_data <= i_load_data;
        end else if (i_mem_wr.write) begin
            o_mem_data <= i_mem_wr.data;
        end
    end
endmodule // rrsb_mem_model

// [test_rrsb_top.sv]
// self-checking bench for the rotate and subtract datapath
`timescale 1ns/1ns
module test_rrsb_top import rrsb_pkg::*; ();
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic v = 1'b0;
    rrsb_op_t op_s = RRSB_OP_NONE;
    logic ld = 1'b0;
    logic [7:0] ld_d = 8'h00;
    logic [7:0] mem_q;
    rrsb_req_t req;
    rrsb_mem_wr_t mem_wr;
    logic [7:0] work;
    rrsb_flags_t flags;
    logic [7:0] ew = 8'h00;
    logic [7:0] em = 8'h00;
    rrsb_flags_t ef = RRSB_FLAGS_RST;
    logic ewr = 1'b0;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    assign req = {v, op_s, mem_q};
    initial begin
        forever #20 clk = ~clk;
    end
    rrsb_top DUT (.i_ref_clk(clk), .i_resetn(rstn), .i_req(req), .o_mem_wr(mem_wr), .o_work_reg(work), .o_flags(flags));
    rrsb_mem_model mem (.i_ref_clk(clk), .i_load(ld), .i_load_data(ld_d), .i_mem_wr(mem_wr), .o_mem_data(mem_q));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmp_all();
        chk(work, ew);
        chk({2'h0, flags}, {2'h0, ef});
        chk({7'h00, mem_wr.write}, {7'h00, ewr});
        if (ewr) begin
            chk(mem_wr.data, em);
        end
    endtask
    // expected state, worked out from the instruction definitions
    task automatic step(input rrsb_op_t op);
        logic [8:0] d;
        logic [4:0] nb;
        logic c;
        logic ov;
        logic b0;
        c = ef.borrow_inverse_bit;
        b0 = em[0];
        d = {1'b0, ew} - {1'b0, em} - {8'h00, ~c};
        nb = {1'b0, ew[3:0]} - {1'b0, em[3:0]} - {4'h0, ~c};
        ov = (ew[7] ^ em[7]) & (d[7] ^ ew[7]);
        ewr = op inside {RRSB_OP_ROT_RIGHT_MEM, RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM, RRSB_OP_SUB_WITH_BORROW_TO_MEM};
        case (op)
            RRSB_OP_ROT_RIGHT_MEM: em = {em[0], em[7:1]};
            RRSB_OP_ROT_RIGHT_TO_WORK_REG: ew = {em[0], em[7:1]};
            RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM: em = {c, em[7:1]};
            RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG: ew = {c, em[7:1]};
            RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG: ew = d[7:0];
            RRSB_OP_SUB_WITH_BORROW_TO_MEM: em = d[7:0];
            default: ;
        endcase
        if (op inside {RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM, RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG}) begin
            ef.borrow_inverse_bit = b0;
        end
        if (op inside {RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG, RRSB_OP_SUB_WITH_BORROW_TO_MEM}) begin
            ef = '{ov, d[7:0] == 8'h00, ~nb[4], ~d[8], d[7] ^ ov, (d[7:0] == 8'h00) & ef.chained_null_flag};
        end
    endtask
    task automatic issue(input rrsb_op_t op);
        @(negedge clk);
        op_s = op;
        v = 1'b1;
        @(negedge clk);
        v = 1'b0;
        step(op);
        cmp_all();
    endtask
    task automatic load(input logic [7:0] b);
        @(negedge clk);
        ld = 1'b1;
        ld_d = b;
        em = b;
        @(negedge clk);
        ld = 1'b0;
    endtask
    task automatic s_rotates();
        load(8'h81);
        issue(RRSB_OP_ROT_RIGHT_MEM);
        load(8'h01);
        issue(RRSB_OP_ROT_RIGHT_TO_WORK_REG);
        load(8'h03);
        issue(RRSB_OP_ROT_RIGHT_THRU_BORROW_MEM);
        load(8'h02);
        issue(RRSB_OP_ROT_RIGHT_THRU_BORROW_TO_WORK_REG);
    endtask
    // work_reg is preset by rotating a pre-rotated byte into it
    task automatic s_sub();
        logic [7:0] wv [4] = '{8'h00, 8'h80, 8'h50, 8'h10};
        logic [7:0] mv [4] = '{8'h01, 8'h01, 8'h50, 8'h0F};
        for (int i = 0; i < 4; i++) begin
            load({wv[i][6:0], wv[i][7]});
            issue(RRSB_OP_ROT_RIGHT_TO_WORK_REG);
            load(mv[i]);
            issue(i[0] ? RRSB_OP_SUB_WITH_BORROW_TO_MEM : RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG);
        end
    endtask
    // back-to-back subtracts chain the borrow, then idle requests must change nothing
    task automatic s_chain();
        load(8'h34);
        @(negedge clk);
        op_s = RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG;
        v = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            step(op_s);
            cmp_all();
            op_s = (i == 0) ? RRSB_OP_SUB_WITH_BORROW_TO_WORK_REG : RRSB_OP_NONE;
        end
        v = 1'b0;
        op_s = RRSB_OP_SUB_WITH_BORROW_TO_MEM;
        @(negedge clk);
        cmp_all();
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        cmp_all();
        s_rotates();
        s_sub();
        s_chain();
        report_and_stop();
    end
endmodule // test_rrsb_top
